// *** shared/btb_pkg.sv ***
// Package with constants and types of the bus controller time base
`default_nettype none
package btb_pkg;
	// Command field codes
	localparam logic [3:0] CMD_CONFIG     = 4'h1;
	localparam logic [3:0] CMD_READY      = 4'h2;
	localparam logic [3:0] CMD_RAM_WIPE   = 4'hC;
	// Protocol state field codes
	localparam logic [5:0] POC_DEFAULT    = 6'h00;
	localparam logic [5:0] POC_CONFIG     = 6'h0F;
	localparam logic [5:0] POC_READY      = 6'h01;
	// Prescale field codes
	localparam logic [1:0] PRE_DIV1       = 2'h0;
	localparam logic [1:0] PRE_DIV2       = 2'h1;
	localparam logic [2:0] SAMPLE_DIV1    = 3'h1;
	localparam logic [2:0] SAMPLE_DIV2    = 3'h2;
	localparam logic [2:0] SAMPLE_DIV4    = 3'h4;
	// Last sampling tick count within a bit and within a microtick
	localparam logic [2:0] SAMPLES_PER_BIT  = 3'h7;
	localparam logic       SAMPLES_PER_UT   = 1'h1;
	// Internal RAM geometry
	localparam int         RAM_AW         = 8;
	localparam int         RAM_DW         = 32;
	localparam int         RAM_DEPTH      = 256;
	localparam logic [RAM_AW-1:0] RAM_LAST = 8'hFF;
	// Timing field widths and reset values
	localparam int         UT_W           = 20;
	localparam int         MT_W           = 14;
	localparam logic [UT_W-1:0] UT_RST    = 20'h00000;
	localparam logic [MT_W-1:0] MT_RST    = 14'h0000;
	localparam logic [4:0] DIV_STEPS      = 5'h14;

	typedef enum logic [1:0] {
		BTB_ST_DEFAULT,
		BTB_ST_CONFIG,
		BTB_ST_READY
	} btb_state_t;

	typedef struct packed {
		logic [1:0]      bit_rate_prescale;
		logic [UT_W-1:0] ut_per_cycle;
		logic [MT_W-1:0] mt_per_cycle;
	} btb_timing_t;
endpackage
`default_nettype wire

// *** design/btb_channel.sv ***
// One bus channel: receive sampling and transmit drive
`default_nettype none
module btb_channel
	import btb_pkg::*;
(
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic sample_tick,
	input  wire logic bit_tick,
	input  wire logic tx_allow,
	input  wire logic tx_req,
	input  wire logic tx_bit,
	input  wire logic rx_in,
	output logic      tx_out,
	output logic      tx_enable_n,
	output logic      rx_bit
);
	logic tx_out_ff;
	logic tx_en_n_ff;
	logic rx_ff;
	logic nxt_tx_out;
	logic nxt_tx_en_n;
	logic nxt_rx;

	// Drive updates only on bit boundaries; idle line is recessive high
	assign nxt_tx_en_n = bit_tick ? ~(tx_allow & tx_req) : tx_en_n_ff; // RULE1
	assign nxt_tx_out  = bit_tick ? (~(tx_allow & tx_req) | tx_bit) : tx_out_ff;
	assign nxt_rx      = sample_tick ? rx_in : rx_ff;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tx_out_ff  <= 1'b1;
			tx_en_n_ff <= 1'b1; // RULE1
			rx_ff      <= 1'b1;
		end else begin
			tx_out_ff  <= nxt_tx_out;
			tx_en_n_ff <= nxt_tx_en_n;
			rx_ff      <= nxt_rx;
		end
	end

	assign tx_out      = tx_out_ff;
	assign tx_enable_n = tx_en_n_ff;
	assign rx_bit      = rx_ff;
endmodule
`default_nettype wire

// *** design/btb_time_base.sv ***
// Time base, RAM clear and configuration gate of the bus controller
// Function
// RULE1: Two channels, tx out, rx in, low-active enable
// RULE2: Reset or wipe command zeroes whole RAM
// RULE3: No settings accepted while RAM clears
// RULE4: Prescale 00/01/1x divides sampling by 1/2/4
// RULE5: Bit clock is sampling clock over eight
// RULE6: Microtick is two sampling periods
// RULE7: Microticks per macrotick computed internally
// RULE8: Timing writes only in configuration state
// RULE9: Reset enters default state, field zero
// RULE10: Command 0001 enters configuration state
// RULE11: RAM clear busy flag readable
`default_nettype none
module btb_time_base
	import btb_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              sys_rst,
	input  wire logic              cmd_valid,
	input  wire logic [3:0]        cmd_code,
	input  wire logic              prtc_wr,
	input  wire logic [1:0]        prtc_prescale,
	input  wire logic              gtu1_wr,
	input  wire logic [UT_W-1:0]   gtu1_ut_per_cycle,
	input  wire logic              gtu2_wr,
	input  wire logic [MT_W-1:0]   gtu2_mt_per_cycle,
	input  wire logic              ram_wr,
	input  wire logic              ram_rd,
	input  wire logic [RAM_AW-1:0] ram_addr,
	input  wire logic [RAM_DW-1:0] ram_wdata,
	output logic [RAM_DW-1:0]      ram_rdata,
	output logic                   ram_init_busy,
	output logic [5:0]             protocol_state_field,
	output btb_timing_t            timing_cfg,
	output logic [UT_W-1:0]        microticks_per_macrotick,
	output logic                   ratio_valid,
	output logic                   sample_tick,
	output logic                   bit_tick,
	output logic                   microtick,
	output logic                   macrotick,
	input  wire logic              tx_req_a,
	input  wire logic              tx_bit_a,
	input  wire logic              tx_req_b,
	input  wire logic              tx_bit_b,
	output logic                   rx_bit_a,
	output logic                   rx_bit_b,
	output logic                   chan_a_tx_out,
	input  wire logic              chan_a_rx_in,
	output logic                   chan_a_tx_enable_n,
	output logic                   chan_b_tx_out,
	input  wire logic              chan_b_rx_in,
	output logic                   chan_b_tx_enable_n
);
	// Internal RAM and its clear sequencer
	logic [RAM_DW-1:0] ram_mem [RAM_DEPTH];
	logic              busy_ff;
	logic [RAM_AW-1:0] clr_addr_ff;
	logic [RAM_DW-1:0] rdata_ff;
	btb_state_t        state_ff;
	btb_state_t        nxt_state;
	btb_timing_t       cfg_ff;
	logic [2:0]        pre_cnt_ff;
	logic [2:0]        bit_cnt_ff;
	logic              ut_cnt_ff;
	logic [UT_W-1:0]   mt_cnt_ff;
	logic [UT_W-1:0]   rem_ff;
	logic [UT_W-1:0]   quot_ff;
	logic [4:0]        div_cnt_ff;
	logic              div_run_ff;
	logic [UT_W-1:0]   ratio_ff;
	logic              ratio_ok_ff;
	logic              bit_tick_ff;

	wire       cmd_ok     = cmd_valid & ~busy_ff; // RULE3
	wire       wipe_cmd   = cmd_ok & (cmd_code == CMD_RAM_WIPE);
	wire       in_config  = (state_ff == BTB_ST_CONFIG);
	wire       wr_gate    = in_config & ~busy_ff; // RULE8 RULE3
	wire       prtc_ok    = prtc_wr & wr_gate; // RULE8
	wire       gtu1_ok    = gtu1_wr & wr_gate; // RULE8
	wire       gtu2_ok    = gtu2_wr & wr_gate; // RULE8
	wire       ram_wr_ok  = ram_wr & ~busy_ff; // RULE3
	wire       clr_last   = (clr_addr_ff == RAM_LAST);
	wire [2:0] pre_div    = (cfg_ff.bit_rate_prescale == PRE_DIV1) ? SAMPLE_DIV1 :
	                        (cfg_ff.bit_rate_prescale == PRE_DIV2) ? SAMPLE_DIV2 :
	                        SAMPLE_DIV4; // RULE4
	wire       samp       = (pre_cnt_ff == (pre_div - 3'h1));
	wire       bit_edge   = samp & (bit_cnt_ff == SAMPLES_PER_BIT); // RULE5
	wire       ut_edge    = samp & (ut_cnt_ff == SAMPLES_PER_UT); // RULE6
	wire       mt_edge    = ut_edge & ratio_ok_ff &
	                        (mt_cnt_ff == (ratio_ff - {{(UT_W-1){1'b0}}, 1'b1}));
	wire [UT_W:0] trial   = {rem_ff, quot_ff[UT_W-1]} - {{(UT_W-MT_W+1){1'b0}}, cfg_ff.mt_per_cycle};
	wire       trial_ok   = ~trial[UT_W];
	wire       div_start  = gtu1_ok | gtu2_ok; // RULE7

	// Protocol state machine
	always_comb begin
		nxt_state = state_ff;
		if (cmd_ok) begin
			case (cmd_code)
				CMD_CONFIG: nxt_state = BTB_ST_CONFIG; // RULE10
				CMD_READY:  nxt_state = in_config ? BTB_ST_READY : state_ff;
				default:    nxt_state = state_ff;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_ff <= BTB_ST_DEFAULT; // RULE9
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_comb begin
		case (state_ff)
			BTB_ST_DEFAULT: protocol_state_field = POC_DEFAULT; // RULE9
			BTB_ST_CONFIG:  protocol_state_field = POC_CONFIG;
			BTB_ST_READY:   protocol_state_field = POC_READY;
			default:        protocol_state_field = POC_DEFAULT;
		endcase
	end

	// Clear runs after reset and on wipe command
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			busy_ff     <= 1'b1; // RULE2
			clr_addr_ff <= '0;
		end else if (wipe_cmd) begin
			busy_ff     <= 1'b1; // RULE2
			clr_addr_ff <= '0;
		end else if (busy_ff) begin
			busy_ff     <= ~clr_last;
			clr_addr_ff <= clr_addr_ff + 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (busy_ff) begin
			ram_mem[clr_addr_ff] <= '0; // RULE2
		end else if (ram_wr_ok) begin
			ram_mem[ram_addr] <= ram_wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rdata_ff <= '0;
		end else if (ram_rd & ~busy_ff) begin
			rdata_ff <= ram_mem[ram_addr];
		end
	end

	// Timing configuration, taken only when allowed
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cfg_ff.bit_rate_prescale <= PRE_DIV1;
			cfg_ff.ut_per_cycle      <= UT_RST;
			cfg_ff.mt_per_cycle      <= MT_RST;
		end else begin
			if (prtc_ok) begin
				cfg_ff.bit_rate_prescale <= prtc_prescale; // RULE8
			end
			if (gtu1_ok) begin
				cfg_ff.ut_per_cycle <= gtu1_ut_per_cycle; // RULE8
			end
			if (gtu2_ok) begin
				cfg_ff.mt_per_cycle <= gtu2_mt_per_cycle; // RULE8
			end
		end
	end

	// Sampling, bit and microtick dividers
	always_ff @(posedge clk) begin
		if (sys_rst | prtc_ok) begin
			pre_cnt_ff <= '0;
			bit_cnt_ff <= '0;
			ut_cnt_ff  <= 1'b0;
		end else begin
			pre_cnt_ff <= samp ? 3'h0 : pre_cnt_ff + 3'h1; // RULE4
			if (samp) begin
				bit_cnt_ff <= bit_cnt_ff + 3'h1; // RULE5
				ut_cnt_ff  <= ~ut_cnt_ff; // RULE6
			end
		end
	end

	// Restoring divider: microticks per cycle over macroticks per cycle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			div_run_ff  <= 1'b0;
			div_cnt_ff  <= '0;
			rem_ff      <= '0;
			quot_ff     <= '0;
			ratio_ff    <= '0;
			ratio_ok_ff <= 1'b0;
		end else if (div_start) begin
			div_run_ff  <= 1'b1;
			div_cnt_ff  <= '0;
			rem_ff      <= '0;
			quot_ff     <= gtu1_ok ? gtu1_ut_per_cycle : cfg_ff.ut_per_cycle;
			ratio_ok_ff <= 1'b0; // RULE7
		end else if (div_run_ff) begin
			if (cfg_ff.mt_per_cycle == MT_RST) begin
				div_run_ff <= 1'b0;
			end else begin
				rem_ff     <= trial_ok ? trial[UT_W-1:0] : {rem_ff[UT_W-2:0], quot_ff[UT_W-1]};
				quot_ff    <= {quot_ff[UT_W-2:0], trial_ok};
				div_cnt_ff <= div_cnt_ff + 5'h01;
				if (div_cnt_ff == (DIV_STEPS - 5'h01)) begin
					div_run_ff  <= 1'b0;
					ratio_ff    <= {quot_ff[UT_W-2:0], trial_ok}; // RULE7
					ratio_ok_ff <= ({quot_ff[UT_W-2:0], trial_ok} != UT_RST);
				end
			end
		end
	end

	// Macrotick from microticks once the ratio is known
	always_ff @(posedge clk) begin
		if (sys_rst | div_start) begin
			mt_cnt_ff <= '0;
		end else if (ut_edge & ratio_ok_ff) begin
			mt_cnt_ff <= mt_edge ? UT_RST : mt_cnt_ff + 20'h00001;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			bit_tick_ff <= 1'b0;
		end else begin
			bit_tick_ff <= bit_edge;
		end
	end

	btb_channel u_chan_a (
		.clk         (clk),
		.sys_rst     (sys_rst),
		.sample_tick (samp),
		.bit_tick    (bit_edge),
		.tx_allow    (state_ff == BTB_ST_READY),
		.tx_req      (tx_req_a),
		.tx_bit      (tx_bit_a),
		.rx_in       (chan_a_rx_in),
		.tx_out      (chan_a_tx_out),
		.tx_enable_n (chan_a_tx_enable_n), // RULE1
		.rx_bit      (rx_bit_a)
	);

	btb_channel u_chan_b (
		.clk         (clk),
		.sys_rst     (sys_rst),
		.sample_tick (samp),
		.bit_tick    (bit_edge),
		.tx_allow    (state_ff == BTB_ST_READY),
		.tx_req      (tx_req_b),
		.tx_bit      (tx_bit_b),
		.rx_in       (chan_b_rx_in),
		.tx_out      (chan_b_tx_out),
		.tx_enable_n (chan_b_tx_enable_n), // RULE1
		.rx_bit      (rx_bit_b)
	);

	assign ram_rdata                = rdata_ff;
	assign ram_init_busy            = busy_ff; // RULE11
	assign timing_cfg               = cfg_ff;
	assign microticks_per_macrotick = ratio_ff;
	assign ratio_valid              = ratio_ok_ff;
	assign sample_tick              = samp;
	assign bit_tick                 = bit_tick_ff;
	assign microtick                = ut_edge;
	assign macrotick                = mt_edge;
endmodule
`default_nettype wire

// *** verif/btb_xcvr_model.sv ***
// Bus transceiver model for one channel
`default_nettype none
module btb_xcvr_model (
	input  wire logic tx_out,
	input  wire logic tx_enable_n,
	output logic      rx_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// Released line returns to its idle high level
	assign rx_in = tx_enable_n ? 1'b1 : tx_out;
endmodule
`default_nettype wire

// *** verif/btb_time_base_chk.sv ***
// Port checker of the time base
`default_nettype none
module btb_time_base_chk
	import btb_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        cmd_valid,
	input  wire logic [3:0]  cmd_code,
	input  wire logic        prtc_wr,
	input  wire logic [1:0]  prtc_prescale,
	input  wire logic        gtu2_wr,
	input  wire logic        ram_init_busy,
	input  wire logic [5:0]  protocol_state_field,
	input  wire btb_timing_t timing_cfg,
	input  wire logic        ratio_valid,
	input  wire logic        bit_tick,
	input  wire logic        sample_tick,
	input  wire logic        microtick,
	input  wire logic        tx_req_a,
	input  wire logic        chan_a_tx_out,
	input  wire logic        chan_a_tx_enable_n,
	input  wire logic        chan_b_tx_out,
	input  wire logic        chan_b_tx_enable_n
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic       cfg_ok;
	logic [9:0] busy_cnt_ff;
	assign cfg_ok = !ram_init_busy && protocol_state_field == POC_CONFIG;
	always_ff @(posedge clk) begin
		busy_cnt_ff <= (sys_rst || !ram_init_busy) ? 10'h000 : busy_cnt_ff + 10'h001;
	end
	a_reset_state: assert property (disable iff (1'b0) sys_rst |=> protocol_state_field == POC_DEFAULT
		&& ram_init_busy && chan_a_tx_enable_n && chan_b_tx_enable_n) else $error("bad reset state");
	a_busy_length: assert property ($fell(ram_init_busy) |-> busy_cnt_ff inside {[10'h0FF:10'h101]})
		else $error("bad clear length");
	a_cmd_blocked: assert property (ram_init_busy && cmd_valid |=> $stable(protocol_state_field))
		else $error("command taken while busy");
	a_cfg_entry: assert property (cmd_valid && !ram_init_busy && cmd_code == CMD_CONFIG
		|=> protocol_state_field == POC_CONFIG) else $error("config not entered");
	a_wr_refused: assert property (prtc_wr && !cfg_ok |=> $stable(timing_cfg.bit_rate_prescale))
		else $error("prescale write not refused");
	a_wr_taken: assert property (prtc_wr && cfg_ok |=> timing_cfg.bit_rate_prescale == $past(prtc_prescale))
		else $error("prescale write lost");
	a_bit_gap: assert property (bit_tick && timing_cfg.bit_rate_prescale == PRE_DIV1 |=> !bit_tick [*7])
		else $error("bit tick too early");
	a_ut_sample: assert property (microtick |-> sample_tick)
		else $error("microtick off sample");
	a_tx_idle: assert property ((chan_a_tx_enable_n |-> chan_a_tx_out) and (chan_b_tx_enable_n |-> chan_b_tx_out))
		else $error("idle tx not high");
	a_tx_gate: assert property ($fell(chan_a_tx_enable_n)
		|-> $past(protocol_state_field) == POC_READY && $past(tx_req_a)) else $error("tx enabled wrongly");
	a_ratio_drop: assert property (gtu2_wr && cfg_ok |=> !ratio_valid [*8])
		else $error("ratio valid too soon");
	c_wipe: cover property (cmd_valid && !ram_init_busy && cmd_code == CMD_RAM_WIPE);
	c_tx: cover property ($fell(chan_a_tx_enable_n));
	c_ratio: cover property ($rose(ratio_valid));
endmodule
bind btb_time_base btb_time_base_chk u_chk (.*);
`default_nettype wire

// *** verif/testbench.sv ***
// Self-checking bench of the time base
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; $display("ERROR %0t: got %h want %h", $time, a, b); end end
module testbench
	import btb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, sys_rst, cmd_valid, prtc_wr, gtu1_wr, gtu2_wr, ram_wr, ram_rd, ram_init_busy, ratio_valid;
	logic sample_tick, bit_tick, microtick, macrotick, tx_req_a, tx_bit_a, tx_req_b, tx_bit_b, rx_bit_a, rx_bit_b;
	logic chan_a_tx_out, chan_a_rx_in, chan_a_tx_enable_n, chan_b_tx_out, chan_b_rx_in, chan_b_tx_enable_n;
	logic [3:0]        cmd_code;
	logic [1:0]        prtc_prescale;
	logic [5:0]        protocol_state_field;
	logic [UT_W-1:0]   gtu1_ut_per_cycle, microticks_per_macrotick;
	logic [MT_W-1:0]   gtu2_mt_per_cycle;
	logic [RAM_AW-1:0] ram_addr;
	logic [RAM_DW-1:0] ram_wdata, ram_rdata;
	btb_timing_t       timing_cfg;
	int                err_count, n_checks, per, d;
	btb_time_base u_dut (.*);
	btb_xcvr_model u_xa (.tx_out(chan_a_tx_out), .tx_enable_n(chan_a_tx_enable_n), .rx_in(chan_a_rx_in));
	btb_xcvr_model u_xb (.tx_out(chan_b_tx_out), .tx_enable_n(chan_b_tx_enable_n), .rx_in(chan_b_rx_in));
	task automatic step(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		step(1);
		s = 1'b0;
		step(1);
	endtask
	task automatic cmd(input logic [3:0] c);
		cmd_code = c;
		pulse(cmd_valid);
	endtask
	task automatic finish_test;
		$display("Checks %0d, errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic wait_idle;
		for (int i = 0; i < 600 && ram_init_busy !== 1'b0; i++) step(1);
		if (ram_init_busy !== 1'b0) begin
			err_count++;
			finish_test;
		end
	endtask
	// Cycles between two pulses, sampled at the falling edge
	task automatic period(ref logic s, output int p);
		for (int i = 0; i < 99 && s !== 1'b1; i++) step(1);
		step(1);
		for (p = 1; p < 99 && s !== 1'b1; p++) step(1);
	endtask
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		{cmd_valid, prtc_wr, gtu1_wr, gtu2_wr, ram_wr, ram_rd, tx_req_a, tx_bit_a, tx_req_b, tx_bit_b, cmd_code,
			prtc_prescale, gtu1_ut_per_cycle, gtu2_mt_per_cycle, ram_addr, ram_wdata} = '0;
		sys_rst = 1'b1;
		step(3);
		sys_rst = 1'b0;
		`CHK(protocol_state_field, POC_DEFAULT)
		`CHK({ram_init_busy, chan_a_tx_enable_n, chan_b_tx_enable_n}, 3'h7)
		cmd(CMD_CONFIG);
		`CHK(protocol_state_field, POC_DEFAULT)
		wait_idle;
		ram_addr = 8'hFF;
		pulse(ram_rd);
		`CHK(ram_rdata, 32'h00000000)
		prtc_prescale = 2'h2;
		pulse(prtc_wr);
		`CHK(timing_cfg.bit_rate_prescale, PRE_DIV1)
		cmd(CMD_CONFIG);
		`CHK(protocol_state_field, POC_CONFIG)
		gtu1_ut_per_cycle = 20'h09C40;
		gtu2_mt_per_cycle = 14'h03E8;
		pulse(gtu1_wr);
		pulse(gtu2_wr);
		step(22);
		`CHK({ratio_valid, microticks_per_macrotick}, {1'b1, 20'h00028})
		`CHK(timing_cfg, {PRE_DIV1, 20'h09C40, 14'h03E8})
		// Forty microticks of two clocks each make one macrotick
		period(macrotick, per);
		`CHK(per, 80)
		gtu2_mt_per_cycle = 14'h0000;
		pulse(gtu2_wr);
		step(22);
		`CHK(ratio_valid, 1'b0)
		for (int p = 0; p < 4; p++) begin
			d = p > 1 ? 4 : p + 1;
			prtc_prescale = 2'(p);
			pulse(prtc_wr);
			period(sample_tick, per);
			`CHK(per, d)
			period(bit_tick, per);
			`CHK(per, 8 * d)
			period(microtick, per);
			`CHK(per, 2 * d)
		end
		prtc_prescale = 2'h0;
		pulse(prtc_wr);
		ram_addr = 8'h05;
		ram_wdata = 32'hA5A5A5A5;
		pulse(ram_wr);
		pulse(ram_rd);
		`CHK(ram_rdata, 32'hA5A5A5A5)
		cmd(CMD_RAM_WIPE);
		`CHK(ram_init_busy, 1'b1)
		prtc_prescale = 2'h1;
		pulse(prtc_wr);
		pulse(ram_rd);
		`CHK({timing_cfg.bit_rate_prescale, ram_rdata}, {PRE_DIV1, 32'hA5A5A5A5})
		wait_idle;
		pulse(ram_rd);
		`CHK(ram_rdata, 32'h00000000)
		cmd(CMD_CONFIG);
		cmd(CMD_READY);
		`CHK(protocol_state_field, POC_READY)
		{tx_req_a, tx_bit_a, tx_req_b, tx_bit_b} = 4'hB;
		step(20);
		`CHK({chan_a_tx_enable_n, chan_a_tx_out, chan_b_tx_enable_n, chan_b_tx_out, rx_bit_a, rx_bit_b}, 6'h05)
		pulse(prtc_wr);
		`CHK(timing_cfg.bit_rate_prescale, PRE_DIV1)
		tx_req_a = 1'b0;
		step(20);
		`CHK({chan_a_tx_enable_n, chan_a_tx_out}, 2'h3)
		finish_test;
	end
endmodule
`default_nettype wire
